// ===== dv/lpm_power_ctrl_props.sv
`timescale 1ns/1ns
module lpm_props (
  // Bus
  input wire        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire [9:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  // Power side
  input wire [2:0]  external_irq_lines,
  input wire        enabled_irq_pending, wake_irq_accept, slow_osc_cfg_on, watchdog_cfg_on,
  input wire        cpu_halt, fast_clk_enable, slow_osc_enable, watchdog_enable, wake_irq_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence pwr_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[9:2] == 8'h87;
  endsequence
  // Four samples cover the two-flop synchroniser plus the state update
  sequence idle_wake;
    (cpu_halt && fast_clk_enable && enabled_irq_pending) [*4];
  endsequence
  sequence stop_wake;
    (!fast_clk_enable && external_irq_lines != 3'h0) [*4];
  endsequence
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a one-cycle answer");
  chk_pwr_unread: assert property (pwr_read ##1 wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("power control read returned data");
  chk_idle_exit: assert property (idle_wake |-> ##[0:1] !cpu_halt)
    else $error("idle not left on pending interrupt");
  chk_stop_exit: assert property (stop_wake |-> ##[0:1] fast_clk_enable)
    else $error("stop not left on external line");
  chk_stop_holds: assert property (!fast_clk_enable && !wake_irq_request && external_irq_lines == 3'h0
    && $past(external_irq_lines) == 3'h0 && $past(external_irq_lines, 2) == 3'h0 |=> !fast_clk_enable)
    else $error("stop left without a wake source");
  chk_stop_halts: assert property (!fast_clk_enable |-> cpu_halt)
    else $error("fast clock stopped while cpu runs");
  chk_osc_follow: assert property (slow_osc_enable == slow_osc_cfg_on)
    else $error("slow oscillator enable off config");
  chk_wdog_follow: assert property (watchdog_enable == watchdog_cfg_on)
    else $error("watchdog enable off config");
  chk_flag_clear: assert property (wake_irq_accept |=> !wake_irq_request)
    else $error("wake flag not cleared on accept");
endmodule // lpm_props

bind lpm_power_ctrl lpm_props u_props (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .external_irq_lines(external_irq_lines), .enabled_irq_pending(enabled_irq_pending),
  .wake_irq_accept(wake_irq_accept), .slow_osc_cfg_on(slow_osc_cfg_on), .watchdog_cfg_on(watchdog_cfg_on),
  .cpu_halt(cpu_halt), .fast_clk_enable(fast_clk_enable), .slow_osc_enable(slow_osc_enable),
  .watchdog_enable(watchdog_enable), .wake_irq_request(wake_irq_request));

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk, resetn, cyc, stb, we, pend, acc, ocfg, wcfg;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat, r;
  logic [2:0]  ext;
  logic        ack, halt, fen, oen, wen, wreq, irq;
  integer      n_errors, n_tests;
  lpm_power_ctrl uut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_irq_lines(ext), .enabled_irq_pending(pend), .wake_irq_accept(acc), .slow_osc_cfg_on(ocfg),
    .watchdog_cfg_on(wcfg), .cpu_halt(halt), .fast_clk_enable(fen), .slow_osc_enable(oen),
    .watchdog_enable(wen), .wake_irq_request(wreq), .irq(irq));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    // Hold until ack is sampled high; only the 50000 ns timeout ends a hung cycle
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task t_regs;
    bus(0, 8'hce, 0); chk("wake ctrl", 0, r);
    bus(0, 8'h87, 0); chk("pwr read", 0, r);
    bus(0, 8'h10, 0); chk("unmapped", 0, r);
    bus(1, 8'hce, 8'h85); bus(0, 8'hce, 0); chk("select", 32'h85, r);
    repeat (200) @(posedge clk);
    chk("no early wake", 0, wreq);
    bus(1, 8'hce, 8'h40); chk("flag out", 1, wreq);
    @(posedge clk) acc <= 1;
    @(posedge clk) acc <= 0;
    bus(0, 8'hce, 0); chk("flag cleared", 0, r);
    $display("regs done");
  endtask
  task t_idle;
    bus(1, 8'h87, 8'h01); chk("idle halt", 1, {halt, fen} == 2'b11);
    repeat (8) @(posedge clk);
    bus(0, 8'hd2, 0); chk("mode idle", 1, r);
    pend <= 1;
    repeat (6) @(posedge clk);
    chk("idle exit", 0, halt); chk("masked", 0, irq);
    pend <= 0;
    bus(1, 8'hd1, 8'h02); bus(0, 8'hd0, 0); chk("status", 2, r); chk("irq", 1, irq);
    bus(1, 8'hd0, 8'h02); bus(0, 8'hd0, 0); chk("cleared", 0, r); chk("irq low", 0, irq);
    $display("idle done");
  endtask
  task t_stop;
    ocfg <= 1;
    wcfg <= 0;
    bus(1, 8'h87, 8'h02); chk("stop", 2'b10, {halt, fen}); chk("osc", 1, oen);
    chk("wdog", 0, wen);
    repeat (8) @(posedge clk);
    pend <= 1;
    repeat (6) @(posedge clk);
    chk("stop kept", 0, fen);
    ext <= 3'b100;
    repeat (6) @(posedge clk);
    chk("stop exit", 2'b01, {halt, fen});
    ext <= 0; pend <= 0;
    bus(0, 8'hd2, 0); chk("mode run", 0, r);
    $display("stop done");
  endtask
  task summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    summarize;
  end
  initial begin
    n_errors = 0; n_tests = 0; resetn = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0;
    ext = 0; pend = 0; acc = 0; ocfg = 1; wcfg = 1;
    repeat (20) @(posedge clk);
    resetn <= 1;
    t_regs;
    t_idle;
    t_stop;
    summarize;
  end
endmodule // testbench

// ===== hdl/lpm_power_ctrl.v
`timescale 1ns/1ns
`include "lpm_defs.vh"
// Function
// - Wake flag cleared when CPU takes interrupt
// - Periodic wake interrupt, interval doubles per code
// - Select bits 3:0, flag bit 6
// - Stop bit halts fast clock, stop mode
// - Stop exits on external irq, timer, reset
// - Slow oscillator, watchdog follow config in stop
// - Idle bit halts CPU, clocks keep running
// - Idle exits on any enabled interrupt
// - Power control write-only, resets to zero
// - Bit 7 starts or stops wake timer
// - Wake timer runs from slow oscillator
module lpm_power_ctrl (
  // System
  input  wire        clk,
  input  wire        resetn,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Wake sources and CPU side
  input  wire [2:0]  external_irq_lines,
  input  wire        enabled_irq_pending,
  input  wire        wake_irq_accept,
  input  wire        slow_osc_cfg_on,
  input  wire        watchdog_cfg_on,
  output wire        cpu_halt,
  output wire        fast_clk_enable,
  output wire        slow_osc_enable,
  output wire        watchdog_enable,
  output wire        wake_irq_request,
  // Interrupt
  output wire        irq
);
  localparam [1:0] ST_RUN  = 2'h0;
  // Mode status reads back these codes
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_STOP = 2'h2;

  // Period in slow ticks for a select code
  // Widest legal code needs 19 bits of count
  function [`LPM_CNT_W-1:0] wake_period;
    input [3:0]  sel;
    reg   [31:0] full;
    begin
      full        = `LPM_BASE_TICKS << sel;
      wake_period = full[`LPM_CNT_W-1:0];
    end
  endfunction

  // Reserved interval codes fold onto the longest period
  function [3:0] clamp_sel;
    input [3:0] code;
    begin
      if (code > `LPM_WT_SEL_MAX) begin
        clamp_sel = `LPM_WT_SEL_MAX;
      end else begin
        clamp_sel = code;
      end
    end
  endfunction

  // Sticky bit: a new event wins over a write-one-clear in the same cycle
  function sticky_next;
    input cur;
    input set_in;
    input clear_in;
    begin
      sticky_next = set_in | (cur & ~clear_in);
    end
  endfunction

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         wake_run_reg;
  reg         wake_flag_reg;
  reg  [3:0]  wake_sel_reg;
  reg  [`LPM_CNT_W-1:0] wake_cnt_reg;
  reg  [`LPM_IRQ_W-1:0] irq_status_reg;
  reg  [`LPM_IRQ_W-1:0] irq_mask_reg;
  reg  [2:0]  ext_meta_reg;
  reg  [2:0]  ext_sync_reg;
  reg         pend_meta_reg;
  reg         pend_sync_reg;
  reg         ack_reg;
  wire        slow_tick;
  wire        wake_event;
  wire        ext_wake;
  wire        exit_event;
  wire [7:0]  idx;
  wire        bus_req;
  wire        wr_lane0;
  wire        pwr_wr;
  wire        wake_wr;
  wire        stop_req;
  wire        idle_req;
  wire        stop_wake_src;
  wire        idle_wake_src;
  wire        status_wr;
  wire        mask_wr;
  wire [`LPM_IRQ_W-1:0] status_clr;
  wire [`LPM_CNT_W-1:0] wake_last;
  reg  [31:0] rd_word;

  assign idx      = wb_adr_i[9:2];
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  assign pwr_wr   = wr_lane0 & (idx == `LPM_IDX_PWR_CTRL);
  assign wake_wr  = wr_lane0 & (idx == `LPM_IDX_WAKE_CTRL);
  assign wb_ack_o = ack_reg;
  assign status_wr  = wr_lane0 & (idx == `LPM_IDX_IRQ_STATUS);
  assign mask_wr    = wr_lane0 & (idx == `LPM_IDX_IRQ_MASK);
  // Only a write to the status word may clear status bits
  assign status_clr = status_wr ? wb_dat_i[`LPM_IRQ_W-1:0] : {`LPM_IRQ_W{1'b0}};
  assign stop_req   = pwr_wr & wb_dat_i[`LPM_PWR_STOP_BIT];
  assign idle_req   = pwr_wr & wb_dat_i[`LPM_PWR_IDLE_BIT];

  // Async irq lines may toggle while the fast clock is gated, so sync them
  // Only the second flop feeds logic; the first may be metastable
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_meta_reg  <= 3'h0;
      ext_sync_reg  <= 3'h0;
      pend_meta_reg <= 1'b0;
      pend_sync_reg <= 1'b0;
    end else begin
      ext_meta_reg  <= external_irq_lines;
      ext_sync_reg  <= ext_meta_reg;
      pend_meta_reg <= enabled_irq_pending;
      pend_sync_reg <= pend_meta_reg;
    end
  end

  assign slow_osc_enable = slow_osc_cfg_on;
  assign watchdog_enable = watchdog_cfg_on;

  lpm_slow_tick u_slow_tick (
    .clk         (clk),
    .resetn      (resetn),
    .slow_osc_on (slow_osc_enable),
    .slow_tick   (slow_tick)
  );

  assign wake_last  = wake_period(wake_sel_reg) - 1'b1;
  assign wake_event = wake_run_reg & slow_tick & (wake_cnt_reg >= wake_last);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_cnt_reg <= {`LPM_CNT_W{1'b0}};
    end else if (!wake_run_reg || wake_wr) begin
      wake_cnt_reg <= {`LPM_CNT_W{1'b0}};
    end else if (slow_tick) begin
      if (wake_event) begin
        wake_cnt_reg <= {`LPM_CNT_W{1'b0}};
      end else begin
        wake_cnt_reg <= wake_cnt_reg + 1'b1;
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_run_reg <= 1'b0;
      wake_sel_reg <= 4'h0;
    end else if (wake_wr) begin
      wake_run_reg <= wb_dat_i[`LPM_WT_RUN_BIT];
      wake_sel_reg <= clamp_sel(wb_dat_i[`LPM_WT_SEL_MSB:`LPM_WT_SEL_LSB]);
    end
  end

  // Hardware set wins so a period is never lost to a late accept
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_flag_reg <= 1'b0;
    end else begin
      if (wake_event) begin
        wake_flag_reg <= 1'b1;
      end else if (wake_irq_accept) begin
        wake_flag_reg <= 1'b0;
      end else if (wake_wr) begin
        wake_flag_reg <= wb_dat_i[`LPM_WT_FLAG_BIT];
      end
    end
  end
  assign wake_irq_request = wake_flag_reg;

  assign ext_wake      = |ext_sync_reg;
  assign stop_wake_src = ext_wake | wake_flag_reg;
  // idle also wakes on any enabled interrupt
  assign idle_wake_src = stop_wake_src | pend_sync_reg;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (stop_req) begin
          state_next = ST_STOP;
        end else if (idle_req) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (idle_wake_src) begin
          state_next = ST_RUN;
        end
      end
      ST_STOP: begin
        // clear mode, resume
        // Other pending interrupts cannot end stop
        if (stop_wake_src) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // One-cycle pulse as a low-power mode ends; feeds the exit status bit
  assign exit_event = (state_reg != ST_RUN) && (state_next == ST_RUN);
  // Stop halts the CPU as well; unlike idle it gates the clock and does not wake on enabled_irq_pending
  // peripherals keep clock in idle
  assign cpu_halt = (state_reg != ST_RUN);
  assign fast_clk_enable = (state_reg != ST_STOP);

  // Sticky status, write one to clear; a new event wins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_reg <= {`LPM_IRQ_W{1'b0}};
      irq_mask_reg   <= {`LPM_IRQ_W{1'b0}};
    end else begin
      if (mask_wr) begin
        irq_mask_reg <= wb_dat_i[`LPM_IRQ_W-1:0];
      end
      irq_status_reg[`LPM_IRQ_WAKE_BIT] <= sticky_next(irq_status_reg[`LPM_IRQ_WAKE_BIT], wake_event,
                                                       status_clr[`LPM_IRQ_WAKE_BIT]);
      irq_status_reg[`LPM_IRQ_EXIT_BIT] <= sticky_next(irq_status_reg[`LPM_IRQ_EXIT_BIT], exit_event,
                                                       status_clr[`LPM_IRQ_EXIT_BIT]);
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read mux; unmapped words read as zero
  always @* begin
    rd_word = 32'h0000_0000;
    case (idx)
      `LPM_IDX_PWR_CTRL:    rd_word = 32'h0000_0000;
      `LPM_IDX_WAKE_CTRL:   rd_word = {24'h000000, wake_run_reg, wake_flag_reg, 2'b00, wake_sel_reg};
      `LPM_IDX_IRQ_STATUS:  rd_word = {30'h0, irq_status_reg};
      `LPM_IDX_IRQ_MASK:    rd_word = {30'h0, irq_mask_reg};
      `LPM_IDX_MODE_STATUS: rd_word = {30'h0, state_reg};
      default:              rd_word = 32'h0000_0000;
    endcase
  end

  // Bus answers one cycle after the strobe; data is zero outside a read answer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_word;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end
endmodule // lpm_power_ctrl

// ===== hdl/lpm_slow_tick.v
`timescale 1ns/1ns
`include "lpm_defs.vh"
// Stand-in for the slow RC oscillator: a one-cycle enable at about 128 kHz
module lpm_slow_tick (
  // System
  input  wire clk,
  input  wire resetn,
  // Control
  input  wire slow_osc_on,
  output reg  slow_tick
);
  localparam [31:0] DIV_FULL = (`LPM_SLOW_DIV) - 1;
  localparam [7:0]  DIV_LAST = DIV_FULL[7:0];
  reg [7:0] div_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg   <= 8'h00;
      slow_tick <= 1'b0;
    end else if (!slow_osc_on) begin
      div_reg   <= 8'h00;
      slow_tick <= 1'b0;
    end else if (div_reg == DIV_LAST) begin
      div_reg   <= 8'h00;
      slow_tick <= 1'b1;
    end else begin
      div_reg   <= div_reg + 8'h01;
      slow_tick <= 1'b0;
    end
  end
endmodule // lpm_slow_tick

// ===== pkg/lpm_defs.vh
`ifndef LPM_DEFS_VH
`define LPM_DEFS_VH

// Register word addresses (byte address = 4 * index)
`define LPM_IDX_PWR_CTRL    8'h87
`define LPM_IDX_WAKE_CTRL   8'hce
`define LPM_IDX_IRQ_STATUS  8'hd0
`define LPM_IDX_IRQ_MASK    8'hd1
`define LPM_IDX_MODE_STATUS 8'hd2

// Power control fields
`define LPM_PWR_IDLE_BIT    0
`define LPM_PWR_STOP_BIT    1

// Wake timer control fields
`define LPM_WT_SEL_MSB      3
`define LPM_WT_SEL_LSB      0
`define LPM_WT_FLAG_BIT     6
`define LPM_WT_RUN_BIT      7
`define LPM_WT_SEL_MAX      4'h8
`define LPM_WT_RESET        8'h00

// Interrupt status bits
`define LPM_IRQ_WAKE_BIT    0
`define LPM_IRQ_EXIT_BIT    1
`define LPM_IRQ_W           2

// Timing: system clock and slow oscillator
`define LPM_CLK_HZ          20000000
`define LPM_SLOW_HZ         128000
// 15.625 ms base period at 128 kHz, in slow ticks
`define LPM_BASE_PERIOD_US  15625
`define LPM_BASE_TICKS      (`LPM_SLOW_HZ / 1000 * `LPM_BASE_PERIOD_US / 1000)
`define LPM_SLOW_DIV        (`LPM_CLK_HZ / `LPM_SLOW_HZ)
`define LPM_CNT_W           20

`endif
